/* core/mss_pkg.sv */
// Package for the MAC statistics increment strobe block.
// Assumes a single clock; frame descriptors arrive already classified by the MAC.
package mss_pkg;

	// ==========================================================
	// Frame length bins
	localparam logic [15:0] LEN_MIN      = 16'h0040; // 64 bytes
	localparam logic [15:0] LEN_BIN127   = 16'h007F;
	localparam logic [15:0] LEN_BIN255   = 16'h00FF;
	localparam logic [15:0] LEN_BIN511   = 16'h01FF;
	localparam logic [15:0] LEN_BIN1023  = 16'h03FF;
	localparam logic [15:0] LEN_BIN1518  = 16'h05EE;
	localparam logic [15:0] MAX_LEN_RST  = 16'h05EE; // Default maximum frame size
	localparam logic        STB_RST      = 1'b0;

	// ==========================================================
	// Frame-end descriptor from the MAC datapath
	typedef enum logic [1:0]
	{
		MSS_UCAST = 2'b00,
		MSS_MCAST = 2'b01,
		MSS_BCAST = 2'b11
	} mss_dest_e;

	typedef struct packed
	{
		logic        done;   // Frame completes this cycle
		logic [15:0] len;    // Frame length in bytes
		mss_dest_e   dest;   // Destination address type
		logic        ctrl;   // Control frame (type 0x8808)
		logic        pause;  // Pause control frame
		logic        fcs_err;// Frame check sequence error
	} mss_frame_s;

	// One-cycle strobe vector for one direction
	typedef struct packed
	{
		logic runt;
		logic b64;
		logic b127;
		logic b255;
		logic b511;
		logic b1023;
		logic b1518;
		logic bmax;
		logic over;
		logic mcast_data_err;
		logic mcast_data_ok;
		logic bcast_data_err;
		logic bcast_data_ok;
		logic ucast_data_err;
		logic ucast_data_ok;
		logic mcast_ctrl;
		logic bcast_ctrl;
		logic ucast_ctrl;
		logic pause;
		logic fcs_err;
		logic fragment;
		logic jabber;
		logic goodlen_fcs_err;
	} mss_stb_s;

	typedef struct packed
	{
		mss_stb_s tx;
		mss_stb_s rx;
	} mss_state_s;

endpackage

/* core/mss_strobes.sv */
// Statistics increment strobe generator for one MAC (TX and RX sides).
// Assumes one clock domain; frame descriptors are synchronous to REF_CLK.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Strobe vectors are always output, with or without the counter option.
// - Every increment strobe is a top-level output port.
// - With counters built, strobes also feed the counter block inputs.
// - TX and RX strobes are generated on the MAC clock.
// - TX 64-byte frame pulses the minimum bin strobe for one cycle.
// - TX frames pulse one of the 65-1518 byte bins for one cycle.
// - TX frame of configured maximum size pulses the max strobe.
// - TX frame above maximum size pulses the oversized strobe.
// - TX non-control frames pulse one of six address/error strobes.
// - Valid TX frames pulse the matching address control-category strobe.
// - Valid TX pause frame pulses the pause strobe.
// - TX frame with FCS error pulses the checksum-error strobe.
// - TX frame under 64 bytes with CRC error pulses fragment strobe.
// - Oversized TX frame with CRC error pulses the jabber strobe.
// - Valid-length TX frame with FCS error pulses goodlen checksum strobe.
// - Received runt packet pulses the runt strobe.
// - RX 64-byte frame pulses the minimum bin strobe.
// - RX frames pulse one of the 65-1518 byte bins.
// - RX frame of configured maximum size pulses the max strobe.
// - RX frame above maximum size pulses the oversized strobe.
// - RX non-control multicast frames pulse the error or valid strobe; broadcast frames pulse only the error strobe.
module mss_strobes
(
	input  wire logic                    REF_CLK,
	input  wire logic                    SRST,
	input  wire logic                    CLK_EN,
	input  wire logic                    COUNTERS_EN,
	input  wire logic [15:0]             MAX_FRAME_LEN,
	input  wire mss_pkg::mss_frame_s     TX_FRAME,
	input  wire mss_pkg::mss_frame_s     RX_FRAME,
	output var  mss_pkg::mss_stb_s       TX_STB,
	output var  mss_pkg::mss_stb_s       RX_STB,
	output var  mss_pkg::mss_stb_s       TX_CNT_INC,
	output var  mss_pkg::mss_stb_s       RX_CNT_INC
);

	// ==========================================================
	// Classification
	mss_pkg::mss_state_s state_q;
	mss_pkg::mss_state_s state_d;
	mss_pkg::mss_stb_s   tx_cnt_q;
	mss_pkg::mss_stb_s   rx_cnt_q;

	// Maps one frame descriptor onto the strobe vector; shared by TX and RX
	function automatic mss_pkg::mss_stb_s classify(input mss_pkg::mss_frame_s f,
		input logic [15:0] maxlen, input logic is_tx);
		mss_pkg::mss_stb_s s;
		logic              ok;
		logic              good_len;
		s        = '0;
		ok       = !f.fcs_err && f.len >= mss_pkg::LEN_MIN && f.len <= maxlen;
		good_len = f.len >= mss_pkg::LEN_MIN && f.len <= maxlen;
		if (f.done)
		begin
			s.runt  = !is_tx && (f.len < mss_pkg::LEN_MIN);
			s.b64   = (f.len == mss_pkg::LEN_MIN);
			s.b127  = (f.len > mss_pkg::LEN_MIN) && (f.len <= mss_pkg::LEN_BIN127);
			s.b255  = (f.len > mss_pkg::LEN_BIN127) && (f.len <= mss_pkg::LEN_BIN255);
			s.b511  = (f.len > mss_pkg::LEN_BIN255) && (f.len <= mss_pkg::LEN_BIN511);
			s.b1023 = (f.len > mss_pkg::LEN_BIN511) && (f.len <= mss_pkg::LEN_BIN1023);
			s.b1518 = (f.len > mss_pkg::LEN_BIN1023) && (f.len <= mss_pkg::LEN_BIN1518);
			s.bmax  = (f.len == maxlen);
			s.over  = (f.len > maxlen);
			// Data frames split by destination and error state
			if (!f.ctrl)
			begin
				s.mcast_data_err = (f.dest == mss_pkg::MSS_MCAST) && !ok;
				s.mcast_data_ok  = (f.dest == mss_pkg::MSS_MCAST) && ok;
				s.bcast_data_err = (f.dest == mss_pkg::MSS_BCAST) && !ok;
				// Remaining RX data classes are outside this block
				s.bcast_data_ok  = is_tx && (f.dest == mss_pkg::MSS_BCAST) && ok;
				s.ucast_data_err = is_tx && (f.dest == mss_pkg::MSS_UCAST) && !ok;
				s.ucast_data_ok  = is_tx && (f.dest == mss_pkg::MSS_UCAST) && ok;
			end
			// Control-category and error classes are TX only here
			if (is_tx)
			begin
				s.mcast_ctrl      = ok && (f.dest == mss_pkg::MSS_MCAST);
				s.bcast_ctrl      = ok && (f.dest == mss_pkg::MSS_BCAST);
				s.ucast_ctrl      = ok && (f.dest == mss_pkg::MSS_UCAST);
				s.pause           = ok && f.ctrl && f.pause;
				s.fcs_err         = f.fcs_err;
				s.fragment        = f.fcs_err && (f.len < mss_pkg::LEN_MIN);
				s.jabber          = f.fcs_err && (f.len > maxlen);
				s.goodlen_fcs_err = f.fcs_err && good_len;
			end
		end
		return s;
	endfunction

	// ==========================================================
	// Next state: reset forces every strobe low
	always_comb
	begin
		state_d = state_q;
		if (SRST)
		begin
			state_d = '0;
		end
		else if (CLK_EN)
		begin
			state_d.tx = classify(TX_FRAME, MAX_FRAME_LEN, 1'b1);
			state_d.rx = classify(RX_FRAME, MAX_FRAME_LEN, 1'b0);
		end
	end

	// ==========================================================
	// State registers; counter copy gated so idle counters see no activity
	always_ff @(posedge REF_CLK)
	begin
		if (SRST || CLK_EN)
		begin
			state_q  <= state_d;
			tx_cnt_q <= (COUNTERS_EN && !SRST) ? state_d.tx : '0;
			rx_cnt_q <= (COUNTERS_EN && !SRST) ? state_d.rx : '0;
		end
	end

	// Strobes always leave the block, counter option or not
	assign TX_STB     = state_q.tx;
	assign RX_STB     = state_q.rx;
	assign TX_CNT_INC = tx_cnt_q;
	assign RX_CNT_INC = rx_cnt_q;

	// ==========================================================
	// Checks
	property p_tx_bin64;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.len == mss_pkg::LEN_MIN) |=> TX_STB.b64;
	endproperty
	a_tx_bin64: assert property (p_tx_bin64) else $error("tx 64 bin missed");

	property p_tx_bin1518;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.len == mss_pkg::LEN_BIN1518) |=> TX_STB.b1518;
	endproperty
	a_tx_bin1518: assert property (p_tx_bin1518) else $error("tx 1518 bin missed");

	property p_tx_over;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.len > MAX_FRAME_LEN) |=> TX_STB.over;
	endproperty
	a_tx_over: assert property (p_tx_over) else $error("tx oversize missed");

	property p_tx_jabber;
		@(posedge REF_CLK) disable iff (SRST)
		TX_STB.jabber |-> TX_STB.over && TX_STB.fcs_err;
	endproperty
	a_tx_jabber: assert property (p_tx_jabber) else $error("tx jabber bad");

	property p_tx_frag;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.fcs_err && TX_FRAME.len < mss_pkg::LEN_MIN)
			|=> TX_STB.fragment;
	endproperty
	a_tx_frag: assert property (p_tx_frag) else $error("tx fragment missed");

	property p_tx_pause;
		@(posedge REF_CLK) disable iff (SRST)
		TX_STB.pause |-> !TX_STB.fcs_err && !TX_STB.over;
	endproperty
	a_tx_pause: assert property (p_tx_pause) else $error("tx pause bad");

	property p_rx_runt;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && RX_FRAME.done && RX_FRAME.len < mss_pkg::LEN_MIN) |=> RX_STB.runt;
	endproperty
	a_rx_runt: assert property (p_rx_runt) else $error("rx runt missed");

	property p_rx_max;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && RX_FRAME.done && RX_FRAME.len == MAX_FRAME_LEN) |=> RX_STB.bmax;
	endproperty
	a_rx_max: assert property (p_rx_max) else $error("rx max missed");

	property p_idle_low;
		@(posedge REF_CLK)
		(SRST || (CLK_EN && !TX_FRAME.done)) |=> (TX_STB == '0);
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("tx strobe while idle");

	property p_cnt_copy;
		@(posedge REF_CLK) disable iff (SRST)
		COUNTERS_EN && CLK_EN |=> TX_CNT_INC == TX_STB;
	endproperty
	a_cnt_copy: assert property (p_cnt_copy) else $error("counter copy differs");

	// ==========================================================
	// Further checks; bins, classes and the clock-enable freeze
	property p_tx_bin127;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.len == mss_pkg::LEN_BIN127) |=> TX_STB.b127;
	endproperty
	a_tx_bin127: assert property (p_tx_bin127) else $error("tx 127 bin missed");

	// Bins must never overlap, else counters double count one frame
	property p_tx_one_bin;
		@(posedge REF_CLK) disable iff (SRST)
		$onehot0({TX_STB.b64, TX_STB.b127, TX_STB.b255, TX_STB.b511, TX_STB.b1023,
			TX_STB.b1518});
	endproperty
	a_tx_one_bin: assert property (p_tx_one_bin) else $error("tx bins overlap");

	property p_tx_max;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.len == MAX_FRAME_LEN) |=> TX_STB.bmax;
	endproperty
	a_tx_max: assert property (p_tx_max) else $error("tx max missed");

	property p_tx_ucast_ok;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && !TX_FRAME.ctrl && !TX_FRAME.fcs_err
			&& TX_FRAME.dest == mss_pkg::MSS_UCAST && TX_FRAME.len >= mss_pkg::LEN_MIN
			&& TX_FRAME.len <= MAX_FRAME_LEN) |=> TX_STB.ucast_data_ok;
	endproperty
	a_tx_ucast_ok: assert property (p_tx_ucast_ok) else $error("tx ucast ok missed");

	property p_tx_mcast_err;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && !TX_FRAME.ctrl && TX_FRAME.fcs_err
			&& TX_FRAME.dest == mss_pkg::MSS_MCAST) |=> TX_STB.mcast_data_err;
	endproperty
	a_tx_mcast_err: assert property (p_tx_mcast_err) else $error("tx mcast err missed");

	property p_tx_bcast_ctrl;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && !TX_FRAME.fcs_err && TX_FRAME.dest == mss_pkg::MSS_BCAST
			&& TX_FRAME.len >= mss_pkg::LEN_MIN && TX_FRAME.len <= MAX_FRAME_LEN)
			|=> TX_STB.bcast_ctrl;
	endproperty
	a_tx_bcast_ctrl: assert property (p_tx_bcast_ctrl) else $error("tx bcast ctrl missed");

	property p_tx_pause_hit;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.ctrl && TX_FRAME.pause && !TX_FRAME.fcs_err
			&& TX_FRAME.len >= mss_pkg::LEN_MIN && TX_FRAME.len <= MAX_FRAME_LEN)
			|=> TX_STB.pause;
	endproperty
	a_tx_pause_hit: assert property (p_tx_pause_hit) else $error("tx pause missed");

	property p_tx_fcs;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.fcs_err) |=> TX_STB.fcs_err;
	endproperty
	a_tx_fcs: assert property (p_tx_fcs) else $error("tx fcs missed");

	property p_tx_jabber_hit;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && TX_FRAME.done && TX_FRAME.fcs_err && TX_FRAME.len > MAX_FRAME_LEN)
			|=> TX_STB.jabber;
	endproperty
	a_tx_jabber_hit: assert property (p_tx_jabber_hit) else $error("tx jabber missed");

	property p_tx_goodlen;
		@(posedge REF_CLK) disable iff (SRST)
		TX_STB.goodlen_fcs_err |-> TX_STB.fcs_err && !TX_STB.over && !TX_STB.fragment;
	endproperty
	a_tx_goodlen: assert property (p_tx_goodlen) else $error("tx goodlen bad");

	property p_rx_runt_bins;
		@(posedge REF_CLK) disable iff (SRST)
		RX_STB.runt |-> !RX_STB.b64 && !RX_STB.b127;
	endproperty
	a_rx_runt_bins: assert property (p_rx_runt_bins) else $error("rx runt in a bin");

	property p_rx_bin64;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && RX_FRAME.done && RX_FRAME.len == mss_pkg::LEN_MIN) |=> RX_STB.b64;
	endproperty
	a_rx_bin64: assert property (p_rx_bin64) else $error("rx 64 bin missed");

	property p_rx_bin255;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && RX_FRAME.done && RX_FRAME.len == mss_pkg::LEN_BIN255) |=> RX_STB.b255;
	endproperty
	a_rx_bin255: assert property (p_rx_bin255) else $error("rx 255 bin missed");

	property p_rx_over;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && RX_FRAME.done && RX_FRAME.len > MAX_FRAME_LEN) |=> RX_STB.over;
	endproperty
	a_rx_over: assert property (p_rx_over) else $error("rx oversize missed");

	property p_rx_mcast_err;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && RX_FRAME.done && !RX_FRAME.ctrl && RX_FRAME.fcs_err
			&& RX_FRAME.dest == mss_pkg::MSS_MCAST) |=> RX_STB.mcast_data_err;
	endproperty
	a_rx_mcast_err: assert property (p_rx_mcast_err) else $error("rx mcast err missed");

	property p_rx_quiet;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && !RX_FRAME.done) |=> (RX_STB == '0);
	endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("rx strobe while idle");

	// A low enable must hold strobes, so a counter sees no extra edge
	property p_freeze;
		@(posedge REF_CLK) disable iff (SRST)
		!CLK_EN |=> $stable(TX_STB) && $stable(RX_STB);
	endproperty
	a_freeze: assert property (p_freeze) else $error("strobes moved while frozen");

	property p_cnt_off;
		@(posedge REF_CLK) disable iff (SRST)
		(CLK_EN && !COUNTERS_EN) |=> (TX_CNT_INC == '0) && (RX_CNT_INC == '0);
	endproperty
	a_cnt_off: assert property (p_cnt_off) else $error("counter feed while off");

	property p_rx_cnt_copy;
		@(posedge REF_CLK) disable iff (SRST)
		(COUNTERS_EN && CLK_EN) |=> (RX_CNT_INC == RX_STB);
	endproperty
	a_rx_cnt_copy: assert property (p_rx_cnt_copy) else $error("rx counter copy differs");

endmodule

`default_nettype wire

/* dv/mss_cnt_model.sv */
// Counter block model: tallies TX 64-byte increments.
// Assumes one-cycle strobes on REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module mss_cnt_model
(
	input  wire logic              REF_CLK,
	input  wire logic              SRST,
	input  wire mss_pkg::mss_stb_s INC,
	output var  logic [15:0]       COUNT
);
	// One count per strobe cycle; a stuck strobe overcounts
	always_ff @(posedge REF_CLK)
		COUNT <= SRST ? 16'h0000 : COUNT + 16'(INC.b64);
endmodule
`default_nettype wire

/* dv/mss_strobes_tb.sv */
// Bench for the statistics strobe block.
// Assumes REF_CLK clocks both directions.
`timescale 1ns/1ps
`default_nettype none
module mss_strobes_tb;
	typedef mss_pkg::mss_frame_s mss_fr_t;
	typedef mss_pkg::mss_stb_s   mss_st_t;
	logic        REF_CLK       = 1'b0;
	logic        SRST          = 1'b1;
	logic        CLK_EN        = 1'b1;
	logic        COUNTERS_EN   = 1'b1;
	logic [15:0] MAX_FRAME_LEN = 16'h05EE;
	mss_fr_t     TX_FRAME      = '0;
	mss_fr_t     RX_FRAME      = '0;
	mss_st_t     TX_STB, RX_STB, TX_CNT_INC, RX_CNT_INC;
	logic [15:0] cnt;
	int          n_mismatch    = 0;
	int          checked       = 0;
	int          cyc           = 0;
	int          n64           = 0;
	mss_strobes dut (.REF_CLK(REF_CLK), .SRST(SRST), .CLK_EN(CLK_EN),
		.COUNTERS_EN(COUNTERS_EN), .MAX_FRAME_LEN(MAX_FRAME_LEN), .TX_FRAME(TX_FRAME),
		.RX_FRAME(RX_FRAME), .TX_STB(TX_STB), .RX_STB(RX_STB), .TX_CNT_INC(TX_CNT_INC),
		.RX_CNT_INC(RX_CNT_INC));
	mss_cnt_model cnt_mdl (.REF_CLK(REF_CLK), .SRST(SRST), .INC(TX_CNT_INC), .COUNT(cnt));
	// ==========================================================
	// Clock, hang guard, helpers
	initial forever #50 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) if (++cyc == 1000) give_verdict(1);
	task automatic give_verdict(input int extra);
		n_mismatch += extra;
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [45:0] seen, input logic [45:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t saw %h exp %h", $time, seen, exp);
		end
	endtask
	function automatic mss_fr_t mk(logic [15:0] l, mss_pkg::mss_dest_e d, logic c, logic e);
		return '{1'b1, l, d, c, c, e};
	endfunction
	// Expected strobes; good means no checksum error and length in range
	function automatic mss_st_t exp_of(input mss_fr_t f, input logic tx);
		mss_st_t s;
		logic g, n, m, b, u, sh;
		s = '0;
		g = !f.fcs_err && f.len >= 16'h0040 && f.len <= MAX_FRAME_LEN;
		n = f.done && !f.ctrl;
		m = f.done && f.dest == mss_pkg::MSS_MCAST;
		b = f.done && f.dest == mss_pkg::MSS_BCAST;
		u = f.done && f.dest == mss_pkg::MSS_UCAST;
		sh = f.done && f.len < 16'h0040;
		s.b64 = f.done && f.len == 16'h0040;
		s.b127 = f.done && f.len inside {[16'h0041:16'h007F]};
		s.b255 = f.done && f.len inside {[16'h0080:16'h00FF]};
		s.b511 = f.done && f.len inside {[16'h0100:16'h01FF]};
		s.b1023 = f.done && f.len inside {[16'h0200:16'h03FF]};
		s.b1518 = f.done && f.len inside {[16'h0400:16'h05EE]};
		s.bmax = f.done && f.len == MAX_FRAME_LEN;
		s.over = f.done && f.len > MAX_FRAME_LEN;
		s.mcast_data_err = n && m && !g;
		s.mcast_data_ok = n && m && g;
		s.bcast_data_err = n && b && !g;
		s.runt = !tx && sh;
		if (!tx)
			return s;
		s.bcast_data_ok = n && b && g;
		s.ucast_data_err = n && u && !g;
		s.ucast_data_ok = n && u && g;
		s.mcast_ctrl = m && g;
		s.bcast_ctrl = b && g;
		s.ucast_ctrl = u && g;
		s.pause = f.done && g && f.pause;
		s.fcs_err = f.done && f.fcs_err;
		s.fragment = sh && f.fcs_err;
		s.jabber = s.over && f.fcs_err;
		s.goodlen_fcs_err = s.fcs_err && !sh && !s.over;
		return s;
	endfunction
	// One frame each way, answer next cycle, then quiet
	task automatic run(input mss_fr_t t, input mss_fr_t r);
		TX_FRAME <= t;
		RX_FRAME <= r;
		@(posedge REF_CLK);
		TX_FRAME.done <= 1'b0;
		RX_FRAME.done <= 1'b0;
		#1 chk({TX_STB, RX_STB}, {exp_of(t, 1'b1), exp_of(r, 1'b0)});
		chk({TX_CNT_INC, RX_CNT_INC}, COUNTERS_EN ? {exp_of(t, 1'b1), exp_of(r, 1'b0)} : '0);
		n64 += COUNTERS_EN && t.done && t.len == 16'h0040;
		@(posedge REF_CLK);
		#1 chk({TX_STB, RX_STB}, '0);
		@(posedge REF_CLK);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_sizes();
		logic [15:0] l[13] = '{16'h003F, 16'h0040, 16'h0041, 16'h007F, 16'h0080, 16'h00FF,
			16'h0100, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05EE, 16'h05EF};
		for (int e = 0; e < 2; e++)
			foreach (l[i])
				run(mk(l[i], mss_pkg::MSS_UCAST, 1'b0, e[0]), mk(l[i], mss_pkg::MSS_MCAST, 1'b0, e[0]));
		MAX_FRAME_LEN <= 16'h03E8;
		run(mk(16'h03E8, mss_pkg::MSS_BCAST, 1'b0, 1'b1), mk(16'h03E9, mss_pkg::MSS_BCAST, 1'b0, 1'b0));
		run(mk(16'h03E9, mss_pkg::MSS_MCAST, 1'b0, 1'b1), mk(16'h03E8, mss_pkg::MSS_UCAST, 1'b0, 1'b0));
		MAX_FRAME_LEN <= 16'h05EE;
	endtask
	task automatic t_class();
		mss_pkg::mss_dest_e d[3] = '{mss_pkg::MSS_UCAST, mss_pkg::MSS_MCAST, mss_pkg::MSS_BCAST};
		foreach (d[i])
			for (int k = 0; k < 4; k++)
				run(mk(16'h0100, d[i], k[1], k[0]), mk(16'h0100, d[i], k[1], k[0]));
	endtask
	// Counter copy gated off, then a frame offered while the clock enable is low
	task automatic t_gate();
		COUNTERS_EN <= 1'b0;
		run(mk(16'h0040, mss_pkg::MSS_UCAST, 1'b0, 1'b0), '0);
		COUNTERS_EN <= 1'b1;
		CLK_EN <= 1'b0;
		TX_FRAME <= mk(16'h0040, mss_pkg::MSS_UCAST, 1'b0, 1'b0);
		repeat (2) @(posedge REF_CLK);
		#1 chk({TX_STB, RX_STB}, '0);
		@(posedge REF_CLK);
		CLK_EN <= 1'b1;
		run(mk(16'h0040, mss_pkg::MSS_MCAST, 1'b0, 1'b0), '0);
	endtask
	// Live strobes must hold while the enable is low
	task automatic t_freeze();
		mss_fr_t f;
		f = mk(16'h0100, mss_pkg::MSS_BCAST, 1'b0, 1'b0);
		TX_FRAME <= f;
		@(posedge REF_CLK);
		TX_FRAME.done <= 1'b0;
		CLK_EN <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		#1 chk(46'(TX_STB), 46'(exp_of(f, 1'b1)));
		@(posedge REF_CLK);
		CLK_EN <= 1'b1;
		@(posedge REF_CLK);
		#1 chk({TX_STB, RX_STB}, '0);
		@(posedge REF_CLK);
	endtask
	// Reset in mid-run swallows a frame; the next one counts again
	task automatic t_reset();
		TX_FRAME <= mk(16'h0040, mss_pkg::MSS_UCAST, 1'b0, 1'b0);
		RX_FRAME <= mk(16'h0040, mss_pkg::MSS_UCAST, 1'b0, 1'b0);
		SRST <= 1'b1;
		@(posedge REF_CLK);
		TX_FRAME.done <= 1'b0;
		RX_FRAME.done <= 1'b0;
		#1 chk({TX_STB, RX_STB}, '0);
		chk({TX_CNT_INC, RX_CNT_INC}, '0);
		@(posedge REF_CLK);
		SRST <= 1'b0;
		n64 = 0;
		run(mk(16'h0040, mss_pkg::MSS_UCAST, 1'b0, 1'b0), '0);
	endtask
	initial
	begin
		repeat (4) @(posedge REF_CLK);
		#1 chk({TX_STB, RX_STB}, '0);
		@(posedge REF_CLK);
		SRST <= 1'b0;
		@(posedge REF_CLK);
		t_sizes();
		t_class();
		t_gate();
		t_freeze();
		chk(46'(cnt), 46'(n64));
		t_reset();
		chk(46'(cnt), 46'(n64));
		give_verdict(0);
	end
endmodule
`default_nettype wire
